// file: common/cbat_bus_if.sv
`timescale 1ns/10ps
`include "cbat_defs.svh"

interface cbat_bus_if;

	//----------------------------------------
	// per-party drives of the shared lines
	//----------------------------------------
	logic                 dev_ts_o;
	logic                 dev_ts_oe;
	logic                 cpu_ts_o;
	logic                 cpu_ts_oe;
	cbat_pkg::cbat_grp_type dev_grp_o;
	logic                 dev_grp_oe;
	cbat_pkg::cbat_grp_type cpu_grp_o;
	logic                 cpu_grp_oe;

	//----------------------------------------
	// single-driver lines, active low
	//----------------------------------------
	logic                 ext_transfer_start_b;
	logic                 address_ack_b;
	logic                 transfer_error_ack_b;
	logic                 transfer_ack_b;
	logic                 cpu0_grant_b;
	logic                 cpu1_grant_shared_b;
	logic                 cpu0_request_b;
	logic                 cpu1_request_b;

	//----------------------------------------
	// resolved wires; pull-ups when undriven
	//----------------------------------------
	logic                 transfer_start_b;
	cbat_pkg::cbat_grp_type grp;

	assign transfer_start_b = dev_ts_oe ? dev_ts_o : (cpu_ts_oe ? cpu_ts_o : 1'b1);
	assign grp = dev_grp_oe ? dev_grp_o : (cpu_grp_oe ? cpu_grp_o : `CBAT_IDLE_GRP);

	modport dev (
		output dev_ts_o, dev_ts_oe, dev_grp_o, dev_grp_oe,
		output address_ack_b, transfer_error_ack_b, transfer_ack_b,
		output cpu0_grant_b, cpu1_grant_shared_b,
		input  transfer_start_b, grp, ext_transfer_start_b,
		input  cpu0_request_b, cpu1_request_b
	);

	modport cpu (
		output cpu_ts_o, cpu_ts_oe, cpu_grp_o, cpu_grp_oe,
		output ext_transfer_start_b, cpu0_request_b, cpu1_request_b,
		input  transfer_start_b, grp, address_ack_b,
		input  transfer_error_ack_b, transfer_ack_b,
		input  cpu0_grant_b, cpu1_grant_shared_b
	);

endinterface : cbat_bus_if

// file: common/cbat_defs.svh
`ifndef CBAT_DEFS_SVH
`define CBAT_DEFS_SVH

//----------------------------------------
// widths of the address-tenure group
//----------------------------------------
`define CBAT_AW          32
`define CBAT_TTW         5
`define CBAT_TSW         3

//----------------------------------------
// fixed codes and timing counts
//----------------------------------------
`define CBAT_SNOOP_TSIZ  3'h2
`define CBAT_ADDRESS_ACK_DLY    2
`define CBAT_CNT_W       4
`define CBAT_IDLE_GRP    '1

`endif

// file: common/cbat_pkg.sv
`include "cbat_defs.svh"

package cbat_pkg;

	//----------------------------------------
	// address-tenure group on the bus
	//----------------------------------------
	typedef struct packed {
		logic [`CBAT_AW-1:0]  addr;
		logic [`CBAT_TTW-1:0] tt;
		logic [`CBAT_TSW-1:0] tsiz;
		logic                 burst_b;
	} cbat_grp_type;

	//----------------------------------------
	// state machines
	//----------------------------------------
	typedef enum logic [4:0] {
		DEV_ARB   = 5'h01,
		DEV_HOLD  = 5'h02,
		DEV_WAITA = 5'h04,
		DEV_GAP   = 5'h08,
		DEV_SNOOP = 5'h10
	} cbat_dev_state_type;

	typedef enum logic [2:0] {
		CPU_IDLE = 3'h1,
		CPU_REQ  = 3'h2,
		CPU_TEN  = 3'h4
	} cbat_cpu_state_type;

	//----------------------------------------
	// whole-module state records
	//----------------------------------------
	typedef struct packed {
		logic         busy;
		logic         start;
		cbat_grp_type grp;
	} cbat_drv_type;

	typedef struct packed {
		cbat_dev_state_type   st;
		logic                 grant0;
		logic                 grant1;
		logic                 ten_busy;
		logic [`CBAT_CNT_W-1:0] cnt;
		logic                 address_ack;
		logic                 strap_s1;
		logic                 strap_s2;
		logic                 strap_done;
		logic                 alt_map;
		logic                 transfer_error_ack;
		logic                 ta;
		logic                 dstore;
		logic                 cpu_start;
		logic                 snoop_done;
		cbat_grp_type         cap;
	} cbat_dev_type;

	typedef struct packed {
		cbat_cpu_state_type st;
		logic               req;
		logic               line_busy;
		logic               ext;
		logic               done;
		logic               err;
		logic               ok;
		cbat_grp_type       job;
	} cbat_cpu_type;

endpackage : cbat_pkg

// file: hdl/cbat_bridge_end.sv
`timescale 1ns/10ps
`include "cbat_defs.svh"
// Notes on behaviour
// RL1 - own tenures only broadcast snoop addresses
// RL2 - idle bus: start one cycle after grant drop
// RL3 - busy bus: start two clocks after ack
// RL4 - transfer start lasts exactly one clock
// RL5 - release start line one clock after ack
// RL6 - incoming start marks a processor tenure
// RL7 - processor starts earliest one cycle after grant
// RL8 - pulled-down extended start is ignored
// RL9 - extended start answered by error ack
// RL10 - error ack disabled: plain ack, data untouched
// RL11 - only processors drive extended start
// RL12 - own address driven with start, held stable
// RL13 - processor address valid with start, stable
// RL14 - burst address aligned to critical double-word
// RL15 - release address group cycle after ack
// RL16 - five-bit type follows address timing
// RL17 - three-bit size follows address timing
// RL18 - snoops are bursts with size code 010
// RL19 - grant primary processor by priority or parking
// RL20 - capture attributes on sampled start

module cbat_bridge_end #(
	parameter int ADDRESS_ACK_DLY = `CBAT_ADDRESS_ACK_DLY      // clocks from start to ack, at least 2
) (
	input  wire logic                        i_clk,        // bus clock
	input  wire logic                        i_rst_b,      // async reset, low
	input  wire logic                        i_ce,         // clock enable
	input  wire logic                        i_dual,       // two processors fitted
	input  wire logic                        i_tea_en,     // error ack enabled
	input  wire logic                        i_xts_map_sel,// strap pin, low = alternate map
	input  wire logic                        i_snoop_req,  // snoop wanted, hold till done
	input  wire logic [`CBAT_AW-1:0]         i_snoop_addr, // snoop address
	input  wire logic [`CBAT_TTW-1:0]        i_snoop_tt,   // snoop type code
	output logic                             o_snoop_done, // snoop tenure ended
	output logic                             o_cpu_start,  // processor tenure began
	output logic [`CBAT_AW-1:0]              o_cpu_addr,   // captured address
	output logic [`CBAT_TTW-1:0]             o_cpu_tt,     // captured type code
	output logic [`CBAT_TSW-1:0]             o_cpu_tsiz,   // captured size code
	output logic                             o_cpu_burst,  // captured burst, high = burst
	output logic                             o_dstore,     // direct-store rejected
	cbat_bus_if.dev                          bus           // processor bus
);

	//----------------------------------------
	// state and helper nets
	//----------------------------------------
	cbat_pkg::cbat_dev_type s_q;
	cbat_pkg::cbat_dev_type s_d;

	logic                   launch;
	logic                   drv_busy;
	logic                   drv_start_b;
	logic                   drv_oe;
	cbat_pkg::cbat_grp_type drv_grp;
	cbat_pkg::cbat_grp_type snoop_grp;
	logic                   ts_seen;
	logic                   xs_seen;
	logic                   line_busy;

	localparam logic [`CBAT_CNT_W-1:0] ACK_LOAD = `CBAT_CNT_W'(ADDRESS_ACK_DLY - 1);
	localparam logic [`CBAT_CNT_W-1:0] CNT_ONE  = `CBAT_CNT_W'h1;

	//----------------------------------------
	// snoop attributes
	//----------------------------------------
	// every snoop is an eight-word burst, so size and burst are fixed
	always_comb begin
		snoop_grp.addr    = i_snoop_addr;     // [RL12]
		snoop_grp.tt      = i_snoop_tt;       // [RL16]
		snoop_grp.tsiz    = `CBAT_SNOOP_TSIZ; // [RL18] [RL17]
		snoop_grp.burst_b = 1'b0;             // [RL18]
	end

	//----------------------------------------
	// bus observation
	//----------------------------------------
	// own start is excluded so it never looks like a processor tenure
	assign ts_seen   = !bus.transfer_start_b && !drv_busy;                 // [RL6]
	// extended start counts only when the strap picked the default map
	assign xs_seen   = !bus.ext_transfer_start_b && !s_q.alt_map
	                   && s_q.strap_done;                                  // [RL8] [RL11]
	assign line_busy = !bus.transfer_start_b || xs_seen || s_q.ten_busy;

	//----------------------------------------
	// next state
	//----------------------------------------
	always_comb begin
		s_d            = s_q;
		launch         = 1'b0;
		s_d.address_ack       = 1'b0;
		s_d.transfer_error_ack        = 1'b0;
		s_d.ta         = 1'b0;
		s_d.dstore     = 1'b0;
		s_d.cpu_start  = 1'b0;
		s_d.snoop_done = 1'b0;

		// strap passes two flops and only the second is read; reset clears
		// both, so extended start stays ignored until the pin has crossed
		s_d.strap_s1   = i_xts_map_sel;
		s_d.strap_s2   = s_q.strap_s1;
		s_d.strap_done = 1'b1;
		s_d.alt_map    = ~s_q.strap_s2;                                    // [RL8]

		// address ack a fixed count after any start, ours or theirs
		if (!s_q.ten_busy && (!bus.transfer_start_b || xs_seen)) begin
			s_d.ten_busy = 1'b1;
			s_d.cnt      = ACK_LOAD;
		end else if (s_q.ten_busy && !s_q.address_ack) begin
			s_d.cnt = s_q.cnt - CNT_ONE;
			if (s_q.cnt == CNT_ONE) begin
				s_d.address_ack = 1'b1;
			end
		end else if (s_q.address_ack) begin
			s_d.ten_busy = 1'b0;
		end

		// capture attributes once, decode uses the copy
		if (ts_seen && !s_q.ten_busy) begin
			s_d.cap       = bus.grp;                                       // [RL20] [RL13]
			s_d.cpu_start = 1'b1;                                          // [RL6]
		end

		// direct-store is unsupported: answer at once, move no data
		if (xs_seen && !s_q.ten_busy) begin
			s_d.dstore = 1'b1;
			if (i_tea_en) begin
				s_d.transfer_error_ack = 1'b1;                                            // [RL9]
			end else begin
				s_d.ta = 1'b1;                                             // [RL10]
			end
		end

		// arbitration and snoop sequencing
		unique case (s_q.st)
			cbat_pkg::DEV_ARB: begin
				if (i_snoop_req) begin
					s_d.st     = cbat_pkg::DEV_HOLD;
					s_d.grant0 = 1'b0;
					s_d.grant1 = 1'b0;
				end else begin
					// primary wins ties and is parked when nobody asks
					s_d.grant1 = i_dual && bus.cpu0_request_b
					             && !bus.cpu1_request_b;                   // [RL19]
					s_d.grant0 = !s_d.grant1;                              // [RL19]
				end
			end
			cbat_pkg::DEV_HOLD: begin
				// a processor granted last cycle may still start now
				if (s_q.address_ack) begin
					s_d.st = cbat_pkg::DEV_GAP;
				end else if (line_busy) begin
					s_d.st = cbat_pkg::DEV_WAITA;
				end else begin
					launch = 1'b1;                                         // [RL2] [RL7]
					s_d.st = cbat_pkg::DEV_SNOOP;
				end
			end
			cbat_pkg::DEV_WAITA: begin
				if (s_q.address_ack) begin
					s_d.st = cbat_pkg::DEV_GAP;                            // [RL3]
				end
			end
			cbat_pkg::DEV_GAP: begin
				launch = 1'b1;                                             // [RL3]
				s_d.st = cbat_pkg::DEV_SNOOP;
			end
			cbat_pkg::DEV_SNOOP: begin
				if (!drv_busy) begin
					s_d.snoop_done = 1'b1;
					s_d.st         = cbat_pkg::DEV_ARB;
				end
			end
		endcase
	end

	//----------------------------------------
	// state register
	//----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q        <= '0;
			s_q.st     <= cbat_pkg::DEV_ARB;
			s_q.grant0 <= 1'b1;
			s_q.cap    <= `CBAT_IDLE_GRP;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	//----------------------------------------
	// snoop tenure driver
	//----------------------------------------
	cbat_tenure_drv u_drv (
		.i_clk     (i_clk),
		.i_rst_b   (i_rst_b),
		.i_ce      (i_ce),
		.i_launch  (launch),
		.i_grp     (snoop_grp),
		.i_address_ack_b  (bus.address_ack_b),
		.o_start_b (drv_start_b),
		.o_oe      (drv_oe),
		.o_grp     (drv_grp),
		.o_busy    (drv_busy)
	);

	//----------------------------------------
	// bus drives
	//----------------------------------------
	assign bus.dev_ts_o             = drv_start_b;                         // [RL4]
	assign bus.dev_ts_oe            = drv_oe;                              // [RL5]
	assign bus.dev_grp_o            = drv_grp;                             // [RL16] [RL17]
	assign bus.dev_grp_oe           = drv_oe;                              // [RL15]
	assign bus.address_ack_b        = ~s_q.address_ack;
	assign bus.transfer_error_ack_b = ~s_q.transfer_error_ack;
	assign bus.transfer_ack_b       = ~s_q.ta;
	assign bus.cpu0_grant_b         = ~s_q.grant0;
	assign bus.cpu1_grant_shared_b  = ~s_q.grant1;

	//----------------------------------------
	// user side
	//----------------------------------------
	assign o_snoop_done = s_q.snoop_done;
	assign o_cpu_start  = s_q.cpu_start;
	assign o_cpu_addr   = s_q.cap.addr;
	assign o_cpu_tt     = s_q.cap.tt;
	assign o_cpu_tsiz   = s_q.cap.tsiz;
	assign o_cpu_burst  = ~s_q.cap.burst_b;
	assign o_dstore     = s_q.dstore;

endmodule : cbat_bridge_end

// file: hdl/cbat_cpu_end.sv
`timescale 1ns/10ps
`include "cbat_defs.svh"

module cbat_cpu_end #(
	parameter bit CPU_ID = 1'b0                          // 0 primary, 1 second processor
) (
	input  wire logic                 i_clk,    // bus clock
	input  wire logic                 i_rst_b,  // async reset, low
	input  wire logic                 i_ce,     // clock enable
	input  wire logic                 i_go,     // start a job, taken when idle
	input  wire logic                 i_ext,    // job is a direct-store access
	input  wire logic [`CBAT_AW-1:0]  i_addr,   // address, double-word aligned
	input  wire logic [`CBAT_TTW-1:0] i_tt,     // type code
	input  wire logic [`CBAT_TSW-1:0] i_tsiz,   // size code
	input  wire logic                 i_burst,  // high = burst
	output logic                      o_busy,   // job in progress
	output logic                      o_done,   // address tenure ended
	output logic                      o_err,    // error ack seen
	output logic                      o_ok,     // transfer ack seen
	cbat_bus_if.cpu                   bus       // processor bus
);

	cbat_pkg::cbat_cpu_type s_q;
	cbat_pkg::cbat_cpu_type s_d;

	logic                   launch;
	logic                   grant;
	logic                   drv_start_b;
	logic                   drv_oe;
	logic                   drv_busy;
	cbat_pkg::cbat_grp_type drv_grp;

	assign grant = CPU_ID ? !bus.cpu1_grant_shared_b : !bus.cpu0_grant_b;

	//----------------------------------------
	// next state
	//----------------------------------------
	// a start elsewhere keeps us off the bus until its ack
	always_comb begin
		s_d      = s_q;
		launch   = 1'b0;
		s_d.done = 1'b0;
		s_d.err  = !bus.transfer_error_ack_b;
		s_d.ok   = !bus.transfer_ack_b;
		if (!bus.address_ack_b) begin
			s_d.line_busy = 1'b0;
		end else if (!drv_busy && (!bus.transfer_start_b || !bus.ext_transfer_start_b)) begin
			s_d.line_busy = 1'b1;
		end
		unique case (s_q.st)
			cbat_pkg::CPU_IDLE: begin
				if (i_go) begin
					s_d.st           = cbat_pkg::CPU_REQ;
					s_d.req          = 1'b1;
					s_d.ext          = i_ext;
					// a burst starts on its double-word, low three bits cleared
					s_d.job.addr     = i_burst ? {i_addr[`CBAT_AW-1:3], 3'h0} : i_addr; // [RL14]
					s_d.job.tt       = i_tt;
					s_d.job.tsiz     = i_tsiz;
					s_d.job.burst_b  = ~i_burst;
				end
			end
			cbat_pkg::CPU_REQ: begin
				// earliest start is the cycle after the grant shows
				if (grant && !s_q.line_busy && bus.transfer_start_b) begin
					launch  = 1'b1;                              // [RL7] [RL11]
					s_d.req = 1'b0;
					s_d.st  = cbat_pkg::CPU_TEN;
				end
			end
			cbat_pkg::CPU_TEN: begin
				if (!drv_busy) begin
					s_d.done = 1'b1;
					s_d.st   = cbat_pkg::CPU_IDLE;
				end
			end
		endcase
	end

	//----------------------------------------
	// state register
	//----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q     <= '0;
			s_q.st  <= cbat_pkg::CPU_IDLE;
			s_q.job <= `CBAT_IDLE_GRP;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	cbat_tenure_drv u_drv (
		.i_clk     (i_clk),
		.i_rst_b   (i_rst_b),
		.i_ce      (i_ce),
		.i_launch  (launch),
		.i_grp     (s_q.job),
		.i_address_ack_b  (bus.address_ack_b),
		.o_start_b (drv_start_b),
		.o_oe      (drv_oe),
		.o_grp     (drv_grp),
		.o_busy    (drv_busy)
	);

	//----------------------------------------
	// bus drives
	//----------------------------------------
	// direct-store pulses the extended line; start stays negated
	assign bus.cpu_ts_o             = s_q.ext | drv_start_b;             // [RL4] [RL13]
	assign bus.cpu_ts_oe            = drv_oe;
	assign bus.ext_transfer_start_b = ~s_q.ext | drv_start_b;            // [RL11]
	assign bus.cpu_grp_o            = drv_grp;                           // [RL13]
	assign bus.cpu_grp_oe           = drv_oe;                            // [RL15]
	assign bus.cpu0_request_b       = ~(s_q.req && !CPU_ID);
	assign bus.cpu1_request_b       = ~(s_q.req && CPU_ID);
	assign o_busy                   = s_q.st != cbat_pkg::CPU_IDLE;
	assign o_done                   = s_q.done;
	assign o_err                    = s_q.err;
	assign o_ok                     = s_q.ok;

endmodule : cbat_cpu_end

// file: hdl/cbat_tenure_drv.sv
`timescale 1ns/10ps

module cbat_tenure_drv (
	input  wire logic                   i_clk,    // bus clock
	input  wire logic                   i_rst_b,  // async reset, low
	input  wire logic                   i_ce,     // clock enable
	input  wire logic                   i_launch, // start a tenure
	input  wire cbat_pkg::cbat_grp_type i_grp,    // attributes to drive
	input  wire logic                   i_address_ack_b, // address ack line
	output logic                        o_start_b,// start pulse, low
	output logic                        o_oe,     // drive enable
	output cbat_pkg::cbat_grp_type      o_grp,    // driven attributes
	output logic                        o_busy    // tenure in progress
);

	cbat_pkg::cbat_drv_type s_q;
	cbat_pkg::cbat_drv_type s_d;

	//----------------------------------------
	// next state
	//----------------------------------------
	// attributes are latched at launch so they stay stable all tenure
	always_comb begin
		s_d       = s_q;
		s_d.start = 1'b0;                // [RL4]
		if (i_launch && !s_q.busy) begin
			s_d.busy  = 1'b1;
			s_d.start = 1'b1;            // [RL1]
			s_d.grp   = i_grp;           // [RL12]
		end else if (s_q.busy && !i_address_ack_b) begin
			s_d.busy  = 1'b0;            // [RL5] [RL15]
		end
	end

	//----------------------------------------
	// state register
	//----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	// start line and group are released together once acked
	assign o_start_b = ~s_q.start;
	assign o_oe      = s_q.busy;
	assign o_grp     = s_q.grp;
	assign o_busy    = s_q.busy;

endmodule : cbat_tenure_drv

// file: testbench/cbat_tenure_checker.sv
`timescale 1ns/10ps

module cbat_tenure_checker #(
	parameter int ADDRESS_ACK_DLY = 2                      // clocks from start to ack
) (
	input  wire logic                   i_clk,                // bus clock
	input  wire logic                   i_rst_b,              // async reset, low
	input  wire logic                   dev_ts_o,             // device start drive
	input  wire logic                   dev_ts_oe,            // device start enable
	input  wire logic                   cpu_ts_oe,            // processor start enable
	input  wire logic                   transfer_start_b,     // resolved start
	input  wire logic                   ext_transfer_start_b, // extended start
	input  wire logic                   address_ack_b,        // address ack
	input  wire logic                   transfer_error_ack_b, // error ack
	input  wire logic                   transfer_ack_b,       // transfer ack
	input  wire logic                   cpu0_grant_b,         // primary grant
	input  wire logic                   cpu1_grant_shared_b,  // second grant
	input  wire cbat_pkg::cbat_grp_type dev_grp_o,            // device group drive
	input  wire logic                   dev_grp_oe            // device group enable
);

	//----------------------------------------
	// one clock domain, async reset
	//----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	// each start, plain or extended, lasts one clock
	a_start_one_clk: assert property ($fell(transfer_start_b) |=> transfer_start_b)
		else $error("start pulse longer than one clock");
	a_ext_one_clk: assert property (!ext_transfer_start_b |=> ext_transfer_start_b)
		else $error("extended start longer than one clock");
	a_idle_start_grant: assert property ((dev_ts_oe && !dev_ts_o && $past(address_ack_b, 2))
		|-> $past(cpu0_grant_b) && $past(cpu1_grant_shared_b))
		else $error("device start without grant negated a cycle before");
	a_busy_start_gap: assert property ((dev_ts_oe && !dev_ts_o) |-> $past(address_ack_b))
		else $error("device start right after address ack");
	a_release_after_ack: assert property ((!address_ack_b && dev_ts_oe) |=> !dev_ts_oe && !dev_grp_oe)
		else $error("device lines still driven after ack");
	a_snoop_burst_size: assert property (dev_grp_oe |-> dev_grp_o.tsiz == 3'h2 && !dev_grp_o.burst_b)
		else $error("snoop size code or burst wrong");
	a_grp_held: assert property ((dev_grp_oe && $past(dev_grp_oe)) |-> $stable(dev_grp_o))
		else $error("device group changed during tenure");
	a_grp_with_start: assert property ((dev_ts_oe && !dev_ts_o) |-> dev_grp_oe && !cpu_ts_oe)
		else $error("device start without its group");
	a_ack_after_start: assert property ($fell(transfer_start_b) |-> ##ADDRESS_ACK_DLY !address_ack_b)
		else $error("address ack not at fixed delay after start");
	a_cpu_after_grant: assert property ((cpu_ts_oe && !transfer_start_b) |-> $past(!cpu0_grant_b))
		else $error("processor start without prior grant");
	a_ack_kinds_apart: assert property (transfer_error_ack_b || transfer_ack_b)
		else $error("error ack and transfer ack together");

endmodule : cbat_tenure_checker

// file: testbench/cpu_bus_address_tenure_tb.sv
`timescale 1ns/10ps

module cpu_bus_address_tenure_tb;

	//----------------------------------------
	// stimulus and bookkeeping
	//----------------------------------------
	logic              i_clk, i_rst_b, tea_en, map_sel, snoop_want, go, xt, burst;
	logic [31:0]       addr, saddr;
	logic [4:0]        tt, stt;
	logic [2:0]        tsiz;
	logic [31:0]       cap_addr;
	logic [4:0]        cap_tt;
	logic [2:0]        cap_tsiz;
	logic              cap_burst, dstore, snoop_done, cpu_start, done, err, ok;
	logic [40:0]       seen_snoop;
	int                ev [6];
	int                mismatches, samples_checked, base, base1;
	localparam logic [40:0] ROWS [4] = '{
		{32'h0000_0000, 5'h00, 3'h0, 1'h0},
		{32'hFFFF_FFF8, 5'h1F, 3'h7, 1'h1},
		{32'h1234_5670, 5'h0A, 3'h2, 1'h1},
		{32'hA5A5_A5A0, 5'h12, 3'h1, 1'h0}};

	cbat_bus_if bus ();

	// request drops in the done cycle so no second snoop is taken
	wire snoop_req = snoop_want && !snoop_done;

	cbat_bridge_end cbat_bridge_end_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'h1), .i_dual(1'h0),
		.i_tea_en(tea_en), .i_xts_map_sel(map_sel), .i_snoop_req(snoop_req), .i_snoop_addr(saddr),
		.i_snoop_tt(stt), .o_snoop_done(snoop_done), .o_cpu_start(cpu_start), .o_cpu_addr(cap_addr),
		.o_cpu_tt(cap_tt), .o_cpu_tsiz(cap_tsiz), .o_cpu_burst(cap_burst), .o_dstore(dstore), .bus(bus.dev));
	cbat_cpu_end cbat_cpu_end_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'h1), .i_go(go), .i_ext(xt),
		.i_addr(addr), .i_tt(tt), .i_tsiz(tsiz), .i_burst(burst), .o_busy(), .o_done(done),
		.o_err(err), .o_ok(ok), .bus(bus.cpu));
	cbat_tenure_checker #(.ADDRESS_ACK_DLY(2)) cbat_tenure_checker_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.dev_ts_o(bus.dev_ts_o), .dev_ts_oe(bus.dev_ts_oe), .cpu_ts_oe(bus.cpu_ts_oe),
		.transfer_start_b(bus.transfer_start_b), .ext_transfer_start_b(bus.ext_transfer_start_b),
		.address_ack_b(bus.address_ack_b), .transfer_error_ack_b(bus.transfer_error_ack_b),
		.transfer_ack_b(bus.transfer_ack_b), .cpu0_grant_b(bus.cpu0_grant_b),
		.cpu1_grant_shared_b(bus.cpu1_grant_shared_b), .dev_grp_o(bus.dev_grp_o), .dev_grp_oe(bus.dev_grp_oe));

	// free-running clock
	initial begin
		i_clk = 1'h0;
		forever #5 i_clk = ~i_clk;
	end

	// pulse counters; counting avoids missing a pulse between waits
	always @(posedge i_clk) begin
		ev[0] += cpu_start;
		ev[1] += done;
		ev[2] += snoop_done;
		ev[3] += dstore;
		ev[4] += err;
		ev[5] += ok;
		if (bus.transfer_start_b === 1'h0 && bus.dev_ts_oe === 1'h1)
			seen_snoop <= bus.grp;
	end

	//----------------------------------------
	// shared tasks
	//----------------------------------------
	task complete_run;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	task check_val(input string nm, input logic [40:0] exp, input logic [40:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : check_val

	// bounded wait for a pulse count; running out ends the run
	task await(input int k, input int target);
		int n;
		n = 0;
		while (ev[k] < target && n < 80) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 80) begin
			mismatches++;
			$display("unexpected wait %0d: expected %0d, seen %0d", k, target, ev[k]);
			complete_run();
		end
	endtask : await

	task job(input logic ext, input logic [40:0] r);
		@(posedge i_clk);
		go <= 1'h1;
		xt <= ext;
		{addr, tt, tsiz, burst} <= r;
		@(posedge i_clk);
		go <= 1'h0;
	endtask : job

	task do_reset(input logic sel);
		@(posedge i_clk);
		i_rst_b <= 1'h0;
		map_sel <= sel;
		repeat (20) @(posedge i_clk);
		i_rst_b <= 1'h1;
		repeat (5) @(posedge i_clk);
	endtask : do_reset

	//----------------------------------------
	// main sequence
	//----------------------------------------
	initial begin
		{i_rst_b, snoop_want, go, xt, burst, addr, tt, tsiz} = '0;
		{tea_en, map_sel, saddr, stt} = {1'h1, 1'h1, 32'h8000_0040, 5'h06};
		repeat (20) @(posedge i_clk);
		i_rst_b <= 1'h1;
		@(negedge i_clk);
		// parked primary grant, idle acks, captures all ones
		check_val("reset_lines", 41'h0F, {bus.cpu0_grant_b, bus.cpu1_grant_shared_b, bus.address_ack_b,
			bus.transfer_error_ack_b, bus.transfer_ack_b});
		// captured burst_b resets high, so the burst output reads low
		check_val("reset_capture", {{40{1'h1}}, 1'h0}, {cap_addr, cap_tt, cap_tsiz, cap_burst});
		repeat (4) @(posedge i_clk);
		// ordinary processor tenures
		foreach (ROWS[i]) begin
			base = ev[1];
			job(1'h0, ROWS[i]);
			await(1, base + 1);
			check_val("capture", ROWS[i], {cap_addr, cap_tt, cap_tsiz, cap_burst});
		end
		check_val("cpu_starts", 41'h4, 41'(ev[0]));
		check_val("idle_grp", {41{1'h1}}, bus.grp);
		// snoop on an idle bus, then one asked for as a processor starts (busy bus)
		for (int k = 0; k < 2; k++) begin
			base  = ev[2];
			base1 = ev[1];
			if (k == 1)
				job(1'h0, ROWS[1]);
			saddr <= 32'h8000_0040 + k * 32'h20;
			stt <= 5'h06 + 5'(k);
			snoop_want <= 1'h1;
			await(2, base + 1);
			snoop_want <= 1'h0;
			check_val("snoop_grp", {32'h8000_0040 + k * 32'h20, 5'h06 + 5'(k), 3'h2, 1'h0}, seen_snoop);
			await(1, base1 + k);
		end
		// direct store: error ack then plain ack
		for (int k = 0; k < 2; k++) begin
			tea_en <= !k;
			base = ev[4 + k];
			job(1'h1, ROWS[2]);
			await(3, ev[3] + 1);
			await(4 + k, base + 1);
			repeat (6) @(posedge i_clk);
		end
		// alternate map strap: extended start has no effect
		do_reset(1'h0);
		base = ev[3];
		job(1'h1, ROWS[3]);
		repeat (30) @(negedge i_clk);
		check_val("alt_map_dstore", 41'(base), 41'(ev[3]));
		complete_run();
	end

endmodule : cpu_bus_address_tenure_tb
